// ==== rtl/line_test_pattern_generator.sv ====
// line test pattern generator with wishbone registers and output buffer
`timescale 1ns/1ns
module line_test_pattern_generator (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [line_test_pkg::WB_AW-1:0] wb_adr_i,
  input wire logic [line_test_pkg::WB_DW/8-1:0] wb_sel_i,
  input wire logic [line_test_pkg::WB_DW-1:0] wb_dat_i,
  output logic [line_test_pkg::WB_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic line_trigger_input_i,
  input wire logic [line_test_pkg::DATA_W-1:0] sensor_data_i,
  input wire logic sensor_valid_i,
  input wire logic sensor_last_i,
  output logic sensor_ready_o,
  output logic [line_test_pkg::DATA_W-1:0] pix_data_o,
  output logic [line_test_pkg::COLOR_W-1:0] pix_color_o,
  output logic pix_line_b_o,
  output logic pix_last_o,
  output logic pix_valid_o,
  input wire logic pix_ready_i
);
  import line_test_pkg::*;

  logic [WB_DW-1:0] ctrl_reg, expo_reg, period_reg, status_word;
  logic wb_req, trig_sync, trig_prev_reg, free_pulse, trig_event, pend_reg;
  logic [PERIOD_W-1:0] free_cnt_reg;
  gen_state_type state_reg, state_next;
  logic [CNT_W-1:0] pix_cnt_reg, len_reg, vpix;
  logic [PIX_W-1:0] mask_reg, start_a_reg, start_b_reg, start_reg;
  logic rgb_reg, moving_reg, cur_b_reg, second_reg;
  logic [LINE_CNT_W-1:0] line_cnt_reg;
  logic [MODE_W-1:0] mode_f;
  logic [ACQ_W-1:0] acq_f;
  logic [DEPTH_W-1:0] depth_f;
  logic [MODEL_W-1:0] model_f;
  logic acq_is_rgb, b_first, test_on, gen_src;
  logic start_line, gen_push, gen_last;
  logic [PIX_W-1:0] depth_mask, raw_sum, raw_val, red_val;
  logic [DATA_W-1:0] gen_data;
  logic [COLOR_W-1:0] gen_color;

  pixel_stream_if buf_in ();
  pixel_stream_if buf_out ();

  // merge written byte lanes into an old register value
  function automatic logic [WB_DW-1:0] merge_lanes(
    input logic [WB_DW-1:0] old_v,
    input logic [WB_DW-1:0] new_v,
    input logic [WB_DW/8-1:0] sel
  );
    logic [WB_DW-1:0] res;
    res = old_v;
    for (int b = 0; b < WB_DW/8; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // control fields
  assign mode_f = ctrl_reg[MODE_LSB +: MODE_W];
  assign acq_f = ctrl_reg[ACQ_LSB +: ACQ_W];
  assign depth_f = ctrl_reg[DEPTH_LSB +: DEPTH_W];
  assign model_f = ctrl_reg[MODEL_LSB +: MODEL_W];
  assign acq_is_rgb = (acq_f == ACQ_RGB);
  assign b_first = (acq_f == ACQ_RAW_B) || (acq_f == ACQ_ENH_B);
  // only documented pattern and mode pairs generate test lines
  assign test_on = ((mode_f == TEST_MOVING) && !acq_is_rgb) ||
    ((mode_f == TEST_RED) && acq_is_rgb);

  // one-cycle ack; a new request waits for ack to drop
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // register writes; exposure is stored but steers nothing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RST;
      expo_reg <= EXPO_RST;
      period_reg <= PERIOD_RST;
    end else if (wb_req && wb_we_i) begin
      case (wb_adr_i)
        CTRL_OFS: ctrl_reg <= merge_lanes(ctrl_reg, wb_dat_i,
          wb_sel_i) & CTRL_MASK;
        EXPO_OFS: expo_reg <= merge_lanes(expo_reg, wb_dat_i,
          wb_sel_i) & EXPO_MASK;
        PERIOD_OFS: period_reg <= merge_lanes(period_reg, wb_dat_i,
          wb_sel_i) & PERIOD_MASK;
        default: ;
      endcase
    end
  end

  // status word gathered from live state
  always_comb begin
    status_word = '0;
    status_word[ST_BUSY] = (state_reg == GEN_RUN);
    status_word[ST_SECOND] = second_reg;
    status_word[ST_PEND] = pend_reg;
    status_word[ST_TEST] = test_on;
    status_word[ST_LCNT_LSB +: LINE_CNT_W] = line_cnt_reg;
  end

  // ack and read data; unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          CTRL_OFS: wb_dat_o <= ctrl_reg;
          EXPO_OFS: wb_dat_o <= expo_reg;
          PERIOD_OFS: wb_dat_o <= period_reg;
          STATUS_OFS: wb_dat_o <= status_word;
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end

  // trigger pin comes from the partner's domain
  level_sync trig_sync_u (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(line_trigger_input_i),
    .sync_o(trig_sync)
  );

  // rising-edge detector on the synchronised trigger
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_prev_reg <= 1'b0;
    end else begin
      trig_prev_reg <= trig_sync;
    end
  end

  // internal free-run line cycle; period 0 fires every clock
  always_ff @(posedge clk_i) begin
    if (rst_i || !ctrl_reg[FREE_BIT]) begin
      free_cnt_reg <= '0;
    end else if (free_pulse) begin
      free_cnt_reg <= '0;
    end else begin
      free_cnt_reg <= free_cnt_reg + 1'b1;
    end
  end
  assign free_pulse = ctrl_reg[FREE_BIT] &&
    (free_cnt_reg >= period_reg[PERIOD_W-1:0]);
  // a stuck trigger simply produces no lines
  assign trig_event = ctrl_reg[FREE_BIT] ? free_pulse :
    (trig_sync && !trig_prev_reg);

  // one pending line; a trigger in the taking cycle is kept
  always_ff @(posedge clk_i) begin
    if (rst_i || !test_on) begin
      pend_reg <= 1'b0;
    end else if (trig_event) begin
      pend_reg <= 1'b1;
    end else if (start_line) begin
      pend_reg <= 1'b0;
    end
  end

  // line length and full-scale mask for the current setup
  always_comb begin
    case (model_f)
      MODEL_2K: vpix = VPIX_2K;
      MODEL_4K: vpix = VPIX_4K;
      default: vpix = VPIX_8K;
    endcase
    case (depth_f)
      DEPTH_8: depth_mask = MASK_8;
      DEPTH_10: depth_mask = MASK_10;
      default: depth_mask = MASK_12;
    endcase
  end

  assign start_line = (state_reg == GEN_IDLE) && pend_reg && test_on;
  assign gen_last = (pix_cnt_reg == len_reg - 1'b1);
  assign gen_push = (state_reg == GEN_RUN) && buf_in.ready;

  // line state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      GEN_IDLE: if (start_line) state_next = GEN_RUN;
      GEN_RUN: if (gen_push && gen_last) state_next = GEN_IDLE;
      default: state_next = GEN_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= GEN_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // per-line snapshot so a mid-line write cannot tear a line
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      len_reg <= VPIX_2K;
      mask_reg <= MASK_8;
      rgb_reg <= 1'b0;
      moving_reg <= 1'b0;
      cur_b_reg <= 1'b0;
      start_reg <= '0;
    end else if (start_line) begin
      // raw lines hold two sensor pixels per virtual pixel
      len_reg <= acq_is_rgb ? vpix : {vpix[CNT_W-2:0], 1'b0};
      mask_reg <= depth_mask;
      rgb_reg <= acq_is_rgb;
      moving_reg <= (mode_f == TEST_MOVING);
      // rgb lines belong to neither sensor line, so no line b flag
      cur_b_reg <= !acq_is_rgb && (b_first ^ second_reg);
      start_reg <= (b_first ^ second_reg) ? start_b_reg : start_a_reg;
    end
  end

  // pixel position restarts at each line
  always_ff @(posedge clk_i) begin
    if (rst_i || start_line) begin
      pix_cnt_reg <= '0;
    end else if (gen_push) begin
      pix_cnt_reg <= pix_cnt_reg + 1'b1;
    end
  end

  // per sensor line start values, stepped after each line
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_a_reg <= '0;
      start_b_reg <= '0;
    end else if (gen_push && gen_last && moving_reg && !rgb_reg) begin
      if (cur_b_reg) begin
        start_b_reg <= start_b_reg + 1'b1;
      end else begin
        start_a_reg <= start_a_reg + 1'b1;
      end
    end
  end

  // line parity; a fresh test session begins with the first line
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      second_reg <= 1'b0;
      line_cnt_reg <= '0;
    end else if (gen_push && gen_last) begin
      second_reg <= !second_reg;
      line_cnt_reg <= line_cnt_reg + 1'b1;
    end else if (!test_on && state_reg == GEN_IDLE) begin
      second_reg <= 1'b0;
    end
  end

  // pixel values; masking a power-of-two scale gives the wrap
  assign raw_sum = start_reg + pix_cnt_reg[CNT_W-1:1];
  assign raw_val = raw_sum & mask_reg;
  assign red_val = pix_cnt_reg[PIX_W-1:0] & mask_reg;

  always_comb begin
    if (rgb_reg) begin
      gen_data = {red_val, {PIX_W{1'b0}}, {PIX_W{1'b0}}};
      gen_color = COLOR_RED;
    end else begin
      gen_data = {{(DATA_W-PIX_W){1'b0}}, raw_val};
      if (cur_b_reg) begin
        gen_color = pix_cnt_reg[0] ? COLOR_BLUE : COLOR_GREEN;
      end else begin
        gen_color = pix_cnt_reg[0] ? COLOR_GREEN : COLOR_RED;
      end
    end
  end

  // source select: a started test line always finishes
  assign gen_src = test_on || (state_reg == GEN_RUN);
  assign buf_in.data = gen_src ? gen_data : sensor_data_i;
  assign buf_in.color = gen_src ? gen_color : COLOR_RED;
  assign buf_in.line_b = gen_src ? cur_b_reg : 1'b0;
  assign buf_in.last = gen_src ? gen_last : sensor_last_i;
  assign buf_in.valid = gen_src ? (state_reg == GEN_RUN) :
    sensor_valid_i;
  // sensor is held off while the pattern owns the stream
  assign sensor_ready_o = buf_in.ready && !gen_src;

  // output buffer absorbs a receiver stall without loss
  skid_buffer2 out_buf_u (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_s(buf_in),
    .out_s(buf_out)
  );

  assign pix_data_o = buf_out.data;
  assign pix_color_o = buf_out.color;
  assign pix_line_b_o = buf_out.line_b;
  assign pix_last_o = buf_out.last;
  assign pix_valid_o = buf_out.valid;
  assign buf_out.ready = pix_ready_i;
endmodule // line_test_pattern_generator

// ==== rtl/line_test_pkg.sv ====
// shared constants and types of the line test pattern generator
package line_test_pkg;
  // bus and data widths
  localparam int WB_AW = 8;
  localparam int WB_DW = 32;
  localparam int PIX_W = 12;
  localparam int DATA_W = 36;
  localparam int CNT_W = 13;
  localparam int LINE_CNT_W = 16;
  localparam int PERIOD_W = 16;
  localparam int COLOR_W = 2;

  // register byte offsets
  localparam logic [WB_AW-1:0] CTRL_OFS = 8'h00;
  localparam logic [WB_AW-1:0] EXPO_OFS = 8'h04;
  localparam logic [WB_AW-1:0] PERIOD_OFS = 8'h08;
  localparam logic [WB_AW-1:0] STATUS_OFS = 8'h0C;

  // control register layout
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 3;
  localparam int ACQ_LSB = 4;
  localparam int ACQ_W = 3;
  localparam int DEPTH_LSB = 8;
  localparam int DEPTH_W = 2;
  localparam int MODEL_LSB = 12;
  localparam int MODEL_W = 2;
  localparam int FREE_BIT = 16;
  localparam logic [WB_DW-1:0] CTRL_MASK = 32'h0001_3377;
  localparam logic [WB_DW-1:0] CTRL_RST = 32'h0000_0000;
  localparam logic [WB_DW-1:0] EXPO_MASK = 32'h0000_FFFF;
  localparam logic [WB_DW-1:0] EXPO_RST = 32'h0000_0000;
  localparam logic [WB_DW-1:0] PERIOD_MASK = 32'h0000_FFFF;
  localparam logic [WB_DW-1:0] PERIOD_RST = 32'h0000_4000;

  // status register layout
  localparam int ST_BUSY = 0;
  localparam int ST_SECOND = 1;
  localparam int ST_PEND = 2;
  localparam int ST_TEST = 3;
  localparam int ST_LCNT_LSB = 16;

  // test image selections
  localparam logic [MODE_W-1:0] TEST_OFF = 3'h0;
  localparam logic [MODE_W-1:0] TEST_MOVING = 3'h2;
  localparam logic [MODE_W-1:0] TEST_RED = 3'h7;

  // line acquisition modes
  localparam logic [ACQ_W-1:0] ACQ_RGB = 3'h0;
  localparam logic [ACQ_W-1:0] ACQ_RAW_A = 3'h1;
  localparam logic [ACQ_W-1:0] ACQ_RAW_B = 3'h2;
  localparam logic [ACQ_W-1:0] ACQ_ENH_A = 3'h3;
  localparam logic [ACQ_W-1:0] ACQ_ENH_B = 3'h4;

  // output depths and their full-scale masks
  localparam logic [DEPTH_W-1:0] DEPTH_8 = 2'h0;
  localparam logic [DEPTH_W-1:0] DEPTH_10 = 2'h1;
  localparam logic [PIX_W-1:0] MASK_8 = 12'h0FF;
  localparam logic [PIX_W-1:0] MASK_10 = 12'h3FF;
  localparam logic [PIX_W-1:0] MASK_12 = 12'hFFF;

  // models and their virtual pixel counts
  localparam logic [MODEL_W-1:0] MODEL_2K = 2'h0;
  localparam logic [MODEL_W-1:0] MODEL_4K = 2'h1;
  localparam logic [CNT_W-1:0] VPIX_2K = 13'h0400;
  localparam logic [CNT_W-1:0] VPIX_4K = 13'h0800;
  localparam logic [CNT_W-1:0] VPIX_8K = 13'h1000;

  // color tag of a raw pixel
  localparam logic [COLOR_W-1:0] COLOR_RED = 2'h0;
  localparam logic [COLOR_W-1:0] COLOR_GREEN = 2'h1;
  localparam logic [COLOR_W-1:0] COLOR_BLUE = 2'h2;

  typedef enum logic [0:0] {
    GEN_IDLE = 1'b0,
    GEN_RUN = 1'b1
  } gen_state_type;
endpackage

// ==== rtl/pixel_stream_if.sv ====
// pixel stream carrier between the generator and its output buffer
`timescale 1ns/1ns
interface pixel_stream_if;
  import line_test_pkg::*;
  logic [DATA_W-1:0] data;
  logic [COLOR_W-1:0] color;
  logic line_b;
  logic last;
  logic valid;
  logic ready;
  modport src (output data, output color, output line_b, output last,
    output valid, input ready);
  modport snk (input data, input color, input line_b, input last,
    input valid, output ready);
endinterface

// ==== rtl/level_sync.sv ====
// two flip-flop synchroniser for a pin level
`timescale 1ns/1ns
module level_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic async_i,
  output logic sync_o
);
  logic meta_reg;

  // first stage is read only by the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end
endmodule // level_sync

// ==== rtl/skid_buffer2.sv ====
// two-entry buffer whose head is always a flip-flop stage
`timescale 1ns/1ns
module skid_buffer2 (
  input wire logic clk_i,
  input wire logic rst_i,
  pixel_stream_if.snk in_s,
  pixel_stream_if.src out_s
);
  import line_test_pkg::*;
  localparam int ENT_W = DATA_W + COLOR_W + 2;
  logic [ENT_W-1:0] head_reg;
  logic [ENT_W-1:0] tail_reg;
  logic head_vld_reg;
  logic tail_vld_reg;
  logic push;
  logic pop;
  logic [ENT_W-1:0] in_word;

  // full only when the tail holds a word
  assign in_s.ready = !tail_vld_reg;
  assign push = in_s.valid && !tail_vld_reg;
  assign pop = head_vld_reg && out_s.ready;
  assign in_word = {in_s.data, in_s.color, in_s.line_b, in_s.last};
  assign out_s.valid = head_vld_reg;
  assign {out_s.data, out_s.color, out_s.line_b, out_s.last} = head_reg;

  // head refills from the tail first so order is kept
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      head_vld_reg <= 1'b0;
      tail_vld_reg <= 1'b0;
      head_reg <= '0;
      tail_reg <= '0;
    end else begin
      if (!head_vld_reg || pop) begin
        if (tail_vld_reg) begin
          head_reg <= tail_reg;
          head_vld_reg <= 1'b1;
          tail_vld_reg <= 1'b0;
        end else begin
          head_reg <= in_word;
          head_vld_reg <= push;
        end
        if (tail_vld_reg && push) begin
          tail_reg <= in_word;
          tail_vld_reg <= 1'b1;
        end
      end else if (push) begin
        tail_reg <= in_word;
        tail_vld_reg <= 1'b1;
      end
    end
  end
endmodule // skid_buffer2

// ==== verif/line_test_props.sv ====
// checker of bus answer, stall hold and raw pair relations
`timescale 1ns/1ns
module line_test_props
  import line_test_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [DATA_W-1:0] pix_data_o,
  input wire logic [COLOR_W-1:0] pix_color_o,
  input wire logic pix_line_b_o,
  input wire logic pix_last_o,
  input wire logic pix_valid_o,
  input wire logic pix_ready_i
);
  logic take;
  logic [COLOR_W-1:0] prev_col_reg;
  logic [DATA_W-1:0] prev_dat_reg;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  assign take = pix_valid_o && pix_ready_i;

  // last accepted pixel, so both halves of a pair can be compared
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_col_reg <= COLOR_RED;
      prev_dat_reg <= '0;
    end else if (take) begin
      prev_col_reg <= pix_color_o;
      prev_dat_reg <= pix_data_o;
    end
  end

  property p_ack_resp;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_ack_cause;
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  // a stalled word must not change under the receiver
  property p_stall_hold;
    pix_valid_o && !pix_ready_i |=> pix_valid_o && $stable(pix_data_o)
      && $stable(pix_color_o) && $stable(pix_last_o);
  endproperty
  property p_red_on_a;
    pix_valid_o && pix_color_o == COLOR_RED |-> !pix_line_b_o;
  endproperty
  property p_blue_on_b;
    pix_valid_o && pix_color_o == COLOR_BLUE |-> pix_line_b_o;
  endproperty
  property p_pair_a;
    take && pix_color_o == COLOR_GREEN && !pix_line_b_o
      |-> prev_col_reg == COLOR_RED && pix_data_o == prev_dat_reg;
  endproperty
  property p_pair_b;
    take && pix_color_o == COLOR_BLUE
      |-> prev_col_reg == COLOR_GREEN && pix_data_o == prev_dat_reg;
  endproperty

  a_ack_resp: assert property (p_ack_resp)
    else $error("ack missing one cycle after request");
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  a_stall_hold: assert property (p_stall_hold)
    else $error("stalled pixel changed");
  a_red_on_a: assert property (p_red_on_a)
    else $error("red pixel on second sensor line");
  a_blue_on_b: assert property (p_blue_on_b)
    else $error("blue pixel on first sensor line");
  a_pair_a: assert property (p_pair_a)
    else $error("green differs from its red partner");
  a_pair_b: assert property (p_pair_b)
    else $error("blue differs from its green partner");

  c_line_b_end: cover property (take && pix_last_o && pix_line_b_o);
  c_stall: cover property (pix_valid_o && !pix_ready_i);
  c_bus: cover property (wb_ack_o);
endmodule // line_test_props

bind line_test_pattern_generator line_test_props props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .pix_data_o(pix_data_o), .pix_color_o(pix_color_o),
  .pix_line_b_o(pix_line_b_o), .pix_last_o(pix_last_o),
  .pix_valid_o(pix_valid_o), .pix_ready_i(pix_ready_i));

// ==== verif/frame_grabber.sv ====
// frame grabber stand-in: line trigger source and stalling pixel sink
`timescale 1ns/1ns
module frame_grabber (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  output logic trig_o,
  output logic ready_o
);
  logic [1:0] tick_reg;

  // slow mode takes one word in four, so the buffer fills
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_reg <= 2'h0;
    end else begin
      tick_reg <= tick_reg + 2'h1;
    end
  end
  assign ready_o = !slow_i || (tick_reg == 2'h0);

  initial trig_o = 1'b0;

  // full high and low phase, long enough for the pin synchroniser
  task automatic fire();
    @(posedge clk_i);
    trig_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    trig_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
endmodule // frame_grabber

// ==== verif/line_test_pattern_generator_tb_top.sv ====
// self-checking bench: register access and pattern line checks
`timescale 1ns/1ns
module line_test_pattern_generator_tb_top;
  import line_test_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, slow, trig, ready, svalid;
  logic ack, pline_b, plast, pvalid, sready, mon_rgb, mon_b;
  logic [WB_AW-1:0] adr;
  logic [WB_DW-1:0] wdat, rdat, dat_o;
  logic [DATA_W-1:0] pdata, ed, st_exp;
  logic [COLOR_W-1:0] pcolor, ec;
  logic [PIX_W-1:0] mask, st_a, st_b, v;
  int fails, n_tests, lines, k, len;
  logic [WB_AW-1:0] offs[4] = '{CTRL_OFS, EXPO_OFS, PERIOD_OFS, 8'h10};
  logic [WB_DW-1:0] rstv[4] = '{CTRL_RST, EXPO_RST, PERIOD_RST, 32'h0000_0000};
  logic [ACQ_W-1:0] acqs[4] = '{ACQ_RAW_A, ACQ_RAW_B, ACQ_ENH_A, ACQ_ENH_B};

  line_test_pattern_generator dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .line_trigger_input_i(trig),
    .sensor_data_i(36'h0_ABCD_1234), .sensor_valid_i(svalid),
    .sensor_last_i(1'b0), .sensor_ready_o(sready), .pix_data_o(pdata),
    .pix_color_o(pcolor), .pix_line_b_o(pline_b), .pix_last_o(plast),
    .pix_valid_o(pvalid), .pix_ready_i(ready));

  frame_grabber grabber (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
    .trig_o(trig), .ready_o(ready));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic check(string what, logic [DATA_W-1:0] e,
      logic [DATA_W-1:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  // one classic cycle; request held until ack is seen at an edge
  task automatic wb_cycle(logic w, logic [WB_AW-1:0] a,
      logic [WB_DW-1:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // reset, then program; start values return to zero with reset
  task automatic cfg(logic [MODE_W-1:0] m, logic [ACQ_W-1:0] a,
      logic [DEPTH_W-1:0] d, logic [MODEL_W-1:0] md, logic f);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    mon_rgb = (a == ACQ_RGB);
    mon_b = (a == ACQ_RAW_B || a == ACQ_ENH_B);
    st_a = '0;
    st_b = '0;
    k = 0;
    lines = 0;
    mask = d == DEPTH_8 ? MASK_8 : d == DEPTH_10 ? MASK_10 : MASK_12;
    len = int'(md == MODEL_2K ? VPIX_2K : md == MODEL_4K ? VPIX_4K : VPIX_8K);
    len = mon_rgb ? len : 2 * len;
    wb_cycle(1'b1, EXPO_OFS, 32'h0000_FFFF);
    wb_cycle(1'b1, PERIOD_OFS, 32'h0000_0800);
    wb_cycle(1'b1, CTRL_OFS, WB_DW'(m) | WB_DW'(a) << ACQ_LSB
      | WB_DW'(d) << DEPTH_LSB | WB_DW'(md) << MODEL_LSB
      | WB_DW'(f) << FREE_BIT);
  endtask

  task automatic wait_lines(int n);
    for (int g = 0; g < 40000 && lines < n; g++) @(posedge clk_i);
    repeat (50) @(posedge clk_i);
    check("lines", DATA_W'(n), DATA_W'(lines));
  endtask

  // score every accepted pixel against the expected line
  always @(posedge clk_i) begin
    if (pvalid === 1'b1 && ready === 1'b1) begin
      v = mon_rgb ? PIX_W'(k) & mask
        : ((mon_b ? st_b : st_a) + PIX_W'(k / 2)) & mask;
      ed = mon_rgb ? {v, 24'h00_0000} : {24'h00_0000, v};
      ec = mon_rgb ? COLOR_RED : mon_b ? (k[0] ? COLOR_BLUE : COLOR_GREEN)
        : (k[0] ? COLOR_GREEN : COLOR_RED);
      check("pixel", ed, pdata);
      check("color", DATA_W'(ec), DATA_W'(pcolor));
      check("line_b", DATA_W'(mon_b & !mon_rgb), DATA_W'(pline_b));
      check("last", DATA_W'(k == len - 1), DATA_W'(plast));
      if (k == len - 1) begin
        lines++;
        k = 0;
        if (!mon_rgb && mon_b) st_b = st_b + 1'b1;
        if (!mon_rgb && !mon_b) st_a = st_a + 1'b1;
        mon_b = mon_rgb ? 1'b0 : !mon_b;
      end else begin
        k++;
      end
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = '0;
    wdat = '0;
    slow = 1'b0;
    svalid = 1'b0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, unmapped offset last
    foreach (offs[i]) begin
      wb_cycle(1'b0, offs[i], 32'h0000_0000);
      check("reg", DATA_W'(rstv[i]), DATA_W'(rdat));
    end
    // test off and buffer empty: sensor may send
    check("sready", DATA_W'(1'b1), DATA_W'(sready));
    // raw variants over all depths; the second one with a stalling sink
    foreach (acqs[i]) begin
      svalid <= 1'b0;
      slow <= (i == 1);
      cfg(TEST_MOVING, acqs[i], DEPTH_W'(i), MODEL_2K, 1'b0);
      check("sready", DATA_W'(1'b0), DATA_W'(sready));
      svalid <= 1'b1;
      for (int n = 2; n <= 4; n += 2) begin
        grabber.fire();
        grabber.fire();
        wait_lines(n);
      end
    end
    svalid <= 1'b0;
    slow <= 1'b0;
    // fixed red on every model, two triggered lines each
    for (int i = 0; i < 3; i++) begin
      cfg(TEST_RED, ACQ_RGB, DEPTH_8, MODEL_W'(i), 1'b0);
      repeat (2) grabber.fire();
      wait_lines(2);
    end
    // free run paced by the period register, no trigger pin
    cfg(TEST_RED, ACQ_RGB, DEPTH_10, MODEL_2K, 1'b1);
    wait_lines(2);
    // two lines done, idle between pulses, pattern still active
    st_exp = DATA_W'(WB_DW'(2) << ST_LCNT_LSB | WB_DW'(1) << ST_TEST);
    wb_cycle(1'b0, STATUS_OFS, 32'h0000_0000);
    check("status", st_exp, DATA_W'(rdat));
    give_verdict();
  end

  // longest run is near 80k cycles; this only cuts a hang
  initial begin
    repeat (95000) @(posedge clk_i);
    fails++;
    give_verdict();
  end
endmodule // line_test_pattern_generator_tb_top
